/* File: verilog/tgo_defs.vh */
`ifndef TGO_DEFS_VH
`define TGO_DEFS_VH

// register word addresses (byte address = index * 4)
`define TGO_ADDR_CTRL     4'h0
`define TGO_ADDR_GATE     4'h1
`define TGO_ADDR_COUNT_LO 4'h2
`define TGO_ADDR_COUNT_HI 4'h3
`define TGO_ADDR_FLAGS    4'h4
`define TGO_ADDR_IRQEN    4'h5
`define TGO_ADDR_BYTETMR  4'h6
`define TGO_ADDR_W        4

// counter control register fields
`define TGO_CTRL_ON       0
`define TGO_CTRL_NOSYNC   2
`define TGO_CTRL_CS_LO    6
`define TGO_CTRL_CS_HI    7
`define TGO_CTRL_RST      8'h00

// gate control register fields
`define TGO_GATE_SS_LO    0
`define TGO_GATE_SS_HI    1
`define TGO_GATE_VAL      2
`define TGO_GATE_GO       3
`define TGO_GATE_SPM      4
`define TGO_GATE_TM       5
`define TGO_GATE_POL      6
`define TGO_GATE_EN       7
`define TGO_GATE_RST      8'h00

// flag and enable register fields
`define TGO_FLG_WRAP      0
`define TGO_FLG_GATE      1
`define TGO_IEN_WRAP      0
`define TGO_IEN_GATE      1
`define TGO_IEN_PERIPH    2
`define TGO_IEN_GLOBAL    3

// gate source codes
`define TGO_SRC_PIN       2'h0
`define TGO_SRC_BYTEWRAP  2'h1
`define TGO_SRC_CMPA      2'h2
`define TGO_SRC_CMPB      2'h3

// external clock select code
`define TGO_CS_EXT        2'h2

`endif

/* File: verilog/tgo_timer_gate.v */
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "tgo_defs.vh"
module tgo_timer_gate #(
  parameter CNT_W = 16,
  parameter BYTE_W = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // avalon-mm slave
  input  wire [`TGO_ADDR_W-1:0] avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  // gate sources and timing
  input  wire              gate_input_pin,
  input  wire              comparator_a_out_synced,
  input  wire              comparator_b_out_synced,
  input  wire              count_tick,
  input  wire              sleep_mode,
  // events to processor and prescaler
  output wire              wrap_irq,
  output wire              gate_irq,
  output wire              wake_request,
  output wire              prescale_clear
);

  reg              rst_meta;
  reg              rst_sync_n;
  reg  [7:0]       counter_control_reg;
  reg              gate_enable_bit;
  reg              gate_polarity_bit;
  reg              gate_toggle_mode_bit;
  reg              gate_single_pulse_bit;
  reg              pulse_acquire_go_done;
  reg  [1:0]       gate_source_select;
  reg  [CNT_W-1:0] count;
  reg  [BYTE_W-1:0] byte_count;
  reg              wrap_flag;
  reg              gate_event_flag;
  reg  [3:0]       irq_enables;
  reg              src_q;
  reg              toggle_q;
  reg              spm_armed;
  reg              gate_level_status;
  reg              gate_level_q;
  reg              ack;
  reg              byte_timer_wrap_pulse;
  reg              next_go;
  reg  [31:0]      next_rdata;
  reg              gate_src;

  wire             counter_on_bit;
  wire             no_sync_bit;
  wire [1:0]       count_clock_select;
  wire             req;
  wire             wr;
  wire             src_rise;
  wire             gate_fall;
  wire             after_toggle;
  wire             gate_open;
  wire             asleep_ok;
  wire             run;
  wire             wr_lo;
  wire             wr_hi;
  wire             go_set;
  wire             cnt_wrap;

  assign counter_on_bit     = counter_control_reg[`TGO_CTRL_ON];
  assign no_sync_bit        = counter_control_reg[`TGO_CTRL_NOSYNC];
  assign count_clock_select = counter_control_reg[`TGO_CTRL_CS_HI:`TGO_CTRL_CS_LO];

  // reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // bus: one wait cycle, answer on second edge
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr              = avs_write & ack;

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // gate source selection
  always @* begin
    case (gate_source_select)
      `TGO_SRC_PIN:      gate_src = gate_input_pin;
      `TGO_SRC_BYTEWRAP: gate_src = byte_timer_wrap_pulse;
      `TGO_SRC_CMPA:     gate_src = comparator_a_out_synced;
      `TGO_SRC_CMPB:     gate_src = comparator_b_out_synced;
      default:           gate_src = gate_input_pin;
    endcase
  end

  // source edge from registered copy, polarity applied first
  assign src_rise     = (gate_src ^ ~gate_polarity_bit) & ~src_q;
  assign after_toggle = gate_toggle_mode_bit ? toggle_q : (gate_src ^ ~gate_polarity_bit);
  // level after single pulse stage; in single pulse mode only passes while armed
  assign gate_open    = gate_single_pulse_bit ? (after_toggle & spm_armed) : after_toggle;
  assign gate_fall    = gate_level_q & ~gate_level_status;
  assign asleep_ok    = ~sleep_mode | (no_sync_bit & (count_clock_select == `TGO_CS_EXT));
  assign run          = counter_on_bit & (~gate_enable_bit | gate_level_status)
                        & count_tick & asleep_ok;
  assign wr_lo        = wr & (avs_address == `TGO_ADDR_COUNT_LO);
  assign wr_hi        = wr & (avs_address == `TGO_ADDR_COUNT_HI);
  assign prescale_clear = wr_lo | wr_hi;
  assign go_set       = wr & (avs_address == `TGO_ADDR_GATE) & avs_writedata[`TGO_GATE_GO];
  assign cnt_wrap     = run & (&count) & ~prescale_clear;

  // go/done: trailing edge clear wins over a set
  always @* begin
    next_go = pulse_acquire_go_done;
    if (wr & (avs_address == `TGO_ADDR_GATE)) begin
      next_go = avs_writedata[`TGO_GATE_GO];
    end
    if (gate_single_pulse_bit & pulse_acquire_go_done & spm_armed & gate_fall) begin
      next_go = 1'b0;
    end
  end

  // gate state flops
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      src_q             <= 1'b0;
      toggle_q          <= 1'b0;
      spm_armed         <= 1'b0;
      gate_level_status <= 1'b0;
      gate_level_q      <= 1'b0;
    end else begin
      src_q <= gate_src ^ ~gate_polarity_bit;
      if (!gate_toggle_mode_bit || !counter_on_bit) begin
        toggle_q <= 1'b0;
      end else if (src_rise) begin
        toggle_q <= ~toggle_q;
      end
      // armed on first counting edge after go; dropped when done
      if (!pulse_acquire_go_done || !gate_single_pulse_bit) begin
        spm_armed <= 1'b0;
      end else if (src_rise) begin
        spm_armed <= 1'b1;
      end
      gate_level_status <= gate_open;
      gate_level_q      <= gate_level_status;
    end
  end

  // companion byte timer; wrap gives a one-cycle high pulse
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      byte_count            <= {BYTE_W{1'b0}};
      byte_timer_wrap_pulse <= 1'b0;
    end else begin
      byte_timer_wrap_pulse <= 1'b0;
      if (wr & (avs_address == `TGO_ADDR_BYTETMR)) begin
        byte_count <= avs_writedata[BYTE_W-1:0];
      end else if (count_tick) begin
        byte_count            <= byte_count + {{(BYTE_W-1){1'b0}}, 1'b1};
        byte_timer_wrap_pulse <= &byte_count;
      end
    end
  end

  // registers, counter and flags
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      counter_control_reg   <= `TGO_CTRL_RST;
      gate_enable_bit       <= 1'b0;
      gate_polarity_bit     <= 1'b0;
      gate_toggle_mode_bit  <= 1'b0;
      gate_single_pulse_bit <= 1'b0;
      pulse_acquire_go_done <= 1'b0;
      gate_source_select    <= `TGO_SRC_PIN;
      count                 <= {CNT_W{1'b0}};
      wrap_flag             <= 1'b0;
      gate_event_flag       <= 1'b0;
      irq_enables           <= 4'h0;
    end else begin
      pulse_acquire_go_done <= next_go;
      if (wr & (avs_address == `TGO_ADDR_CTRL)) begin
        counter_control_reg <= avs_writedata[7:0];
      end
      if (wr & (avs_address == `TGO_ADDR_GATE)) begin
        gate_enable_bit       <= avs_writedata[`TGO_GATE_EN];
        gate_polarity_bit     <= avs_writedata[`TGO_GATE_POL];
        gate_toggle_mode_bit  <= avs_writedata[`TGO_GATE_TM];
        gate_single_pulse_bit <= avs_writedata[`TGO_GATE_SPM];
        gate_source_select    <= avs_writedata[`TGO_GATE_SS_HI:`TGO_GATE_SS_LO];
      end
      if (wr & (avs_address == `TGO_ADDR_IRQEN)) begin
        irq_enables <= avs_writedata[3:0];
      end
      if (wr_lo) begin
        count[7:0] <= avs_writedata[7:0];
      end else if (wr_hi) begin
        count[CNT_W-1:8] <= avs_writedata[CNT_W-9:0];
      end else if (run) begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      // write-one-to-clear; a set in the same cycle wins
      if (cnt_wrap) begin
        wrap_flag <= 1'b1;
      end else if (wr & (avs_address == `TGO_ADDR_FLAGS) & avs_writedata[`TGO_FLG_WRAP]) begin
        wrap_flag <= 1'b0;
      end
      if (gate_fall) begin
        gate_event_flag <= 1'b1;
      end else if (wr & (avs_address == `TGO_ADDR_FLAGS) & avs_writedata[`TGO_FLG_GATE]) begin
        gate_event_flag <= 1'b0;
      end
    end
  end

  assign wrap_irq = wrap_flag & counter_on_bit & irq_enables[`TGO_IEN_WRAP]
                    & irq_enables[`TGO_IEN_PERIPH] & irq_enables[`TGO_IEN_GLOBAL];
  assign gate_irq = gate_event_flag & irq_enables[`TGO_IEN_GATE]
                    & irq_enables[`TGO_IEN_PERIPH] & irq_enables[`TGO_IEN_GLOBAL];
  assign wake_request = wrap_flag & counter_on_bit & irq_enables[`TGO_IEN_WRAP]
                        & irq_enables[`TGO_IEN_PERIPH];

  // read mux
  always @* begin
    next_rdata = 32'h00000000;
    case (avs_address)
      `TGO_ADDR_CTRL:     next_rdata[7:0] = counter_control_reg;
      `TGO_ADDR_GATE:     next_rdata[7:0] = {gate_enable_bit, gate_polarity_bit,
                                             gate_toggle_mode_bit, gate_single_pulse_bit,
                                             pulse_acquire_go_done, gate_level_status,
                                             gate_source_select};
      `TGO_ADDR_COUNT_LO: next_rdata[7:0] = count[7:0];
      `TGO_ADDR_COUNT_HI: next_rdata[CNT_W-9:0] = count[CNT_W-1:8];
      `TGO_ADDR_FLAGS:    next_rdata[1:0] = {gate_event_flag, wrap_flag};
      `TGO_ADDR_IRQEN:    next_rdata[3:0] = irq_enables;
      `TGO_ADDR_BYTETMR:  next_rdata[BYTE_W-1:0] = byte_count;
      default:            next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_rdata;
    end
  end

endmodule // tgo_timer_gate

/* File: tb/tgo_timer_gate_props.sv */
`timescale 1ns/1ns
module tgo_timer_gate_props (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // bus side
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // events
  input wire        wrap_irq,
  input wire        gate_irq,
  input wire        wake_request,
  input wire        prescale_clear
);
  wire req = avs_read | avs_write;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence fresh_s;
    req && !$past(req);
  endsequence
  sequence held_s;
    req && avs_waitrequest ##1 req;
  endsequence
  first_wait_a: assert property (fresh_s |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  one_wait_a: assert property (held_s |-> !avs_waitrequest)
    else $error("more than one wait cycle");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("stall without request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  wake_cover_a: assert property (wrap_irq |-> wake_request)
    else $error("wrap irq without wake");
  wrap_sticky_a: assert property (wake_request && !avs_write |=> wake_request)
    else $error("wrap request dropped by itself");
  gate_sticky_a: assert property (gate_irq && !avs_write |=> gate_irq)
    else $error("gate request dropped by itself");
  pclr_pulse_a: assert property (prescale_clear |=> !prescale_clear)
    else $error("prescale clear longer than one cycle");
  pclr_cause_a: assert property (prescale_clear |-> avs_write || $past(avs_write))
    else $error("prescale clear without write");
endmodule // tgo_timer_gate_props

bind tgo_timer_gate tgo_timer_gate_props tgo_timer_gate_props_inst (.clk, .rst_n, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .wrap_irq, .gate_irq, .wake_request,
  .prescale_clear);

/* File: tb/tgo_src_model.sv */
`timescale 1ns/1ns
module tgo_src_model (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // bench control
  input  wire [2:0] lv,
  input  wire [7:0] nb,
  input  wire       ld,
  // sources
  output wire       pin,
  output wire       cma,
  output wire       cmb,
  output reg        tick
);
  reg [7:0] left;
  assign {cmb, cma, pin} = lv;
  // burst of nb ticks, one every other cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 8'h00;
      tick <= 1'b0;
    end else if (ld) begin
      left <= nb;
    end else begin
      tick <= !tick && left != 8'h00;
      if (tick) left <= left - 8'h01;
    end
  end
endmodule // tgo_src_model

/* File: tb/tb_tgo_timer_gate.sv */
`timescale 1ns/1ns
`include "tgo_defs.vh"
module tb_tgo_timer_gate;
  localparam [3:0] a_ct = `TGO_ADDR_CTRL;
  localparam [3:0] a_gt = `TGO_ADDR_GATE;
  localparam [3:0] a_lo = `TGO_ADDR_COUNT_LO;
  localparam [3:0] a_fl = `TGO_ADDR_FLAGS;
  localparam [3:0] a_ie = `TGO_ADDR_IRQEN;
  reg         clk, rst_n, rd, wr, slp, ld;
  reg  [3:0]  adr;
  reg  [31:0] wd, rdat;
  reg  [2:0]  lv, v;
  reg  [7:0]  nb, ec;
  wire [31:0] rdd;
  wire        wt, pin, cma, cmb, tick, wirq, girq, wake, pclr;
  integer     mismatches, total_checks, npc, s, p, l;
  tgo_timer_gate tgo_timer_gate_inst (.clk(clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdd),
    .avs_waitrequest(wt), .gate_input_pin(pin), .comparator_a_out_synced(cma),
    .comparator_b_out_synced(cmb), .count_tick(tick), .sleep_mode(slp),
    .wrap_irq(wirq), .gate_irq(girq), .wake_request(wake), .prescale_clear(pclr));
  tgo_src_model tgo_src_model_inst (.clk(clk), .rst_n(rst_n), .lv(lv), .nb(nb), .ld(ld),
    .pin(pin), .cma(cma), .cmb(cmb), .tick(tick));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (pclr === 1'b1) npc = npc + 1;
  task chk(input [31:0] sn, input [31:0] ex);
    begin
      total_checks = total_checks + 1;
      if (sn !== ex) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, sn, ex);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wd <= {24'h000000, d};
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wt !== 1'b0) @(posedge clk);
      rdat = rdd;
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
    end
  endtask
  task step(input [2:0] lvl, input [7:0] n);
    begin
      @(posedge clk);
      lv <= lvl;
      repeat (4) @(posedge clk);
      nb <= n;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      repeat (2 * n + 4) @(posedge clk);
    end
  endtask
  task cnt(input [7:0] inc);
    begin
      ec = ec + inc;
      acc(0, a_lo, 8'h00);
      chk(rdat, {24'h000000, ec});
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    {mismatches, total_checks, npc, rst_n, rd, wr, slp, ld} = 0;
    {adr, wd, lv, nb, ec} = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (s = 0; s < 7; s = s + 1) begin
      acc(0, s, 8'h00);
      chk(rdat & 32'hFFFFFFFB, 0);
    end
    acc(1, 4'hF, 8'h5A);
    acc(0, 4'hF, 8'h00);
    chk(rdat, 0);
    acc(1, `TGO_ADDR_COUNT_HI, 8'hA5);
    acc(1, a_lo, 8'h00);
    chk(npc, 2);
    step(0, 5);
    cnt(0);
    acc(1, a_ct, 8'h01);
    step(0, 10);
    cnt(10);
    $display("end of test basic");
    for (s = 0; s < 4; s = s + 1) for (p = 0; p < 2; p = p + 1) for (l = 0; l < 2; l++) begin
      if (s != 1) begin
        acc(1, a_gt, {1'b1, p[0], 4'h0, s[1:0]});
        v = 3'd1 << ((s == 0) ? 0 : s - 1);
        step(l ? v : ~v, 3);
        acc(0, a_gt, 8'h00);
        chk(rdat[2], l == p);
        cnt((l == p) ? 3 : 0);
      end
    end
    $display("end of test gate");
    acc(1, a_gt, 8'h40);
    step(1, 0);
    acc(1, a_fl, 8'h03);
    acc(0, a_gt, 8'h00);
    chk(rdat[2], 1);
    acc(1, a_ie, 8'h0E);
    step(0, 0);
    chk(girq, 1);
    acc(1, a_fl, 8'h02);
    chk(girq, 0);
    acc(1, a_gt, 8'h41);
    acc(1, `TGO_ADDR_BYTETMR, 8'hFF);
    step(0, 1);
    chk(girq, 1);
    cnt(1);
    acc(1, a_fl, 8'h03);
    $display("end of test event");
    acc(1, `TGO_ADDR_COUNT_HI, 8'hFF);
    acc(1, a_lo, 8'hFE);
    ec = 8'hFE;
    acc(1, a_ie, 8'h05);
    step(0, 2);
    cnt(2);
    chk({wake, wirq}, 2'b10);
    acc(1, a_ie, 8'h0D);
    chk(wirq, 1);
    acc(1, a_ct, 8'h00);
    chk({wake, wirq}, 0);
    acc(1, a_ct, 8'h01);
    acc(1, a_fl, 8'h01);
    chk(wirq, 0);
    @(posedge clk);
    slp <= 1'b1;
    step(0, 3);
    cnt(0);
    acc(1, a_ct, 8'h85);
    step(0, 3);
    cnt(3);
    @(posedge clk);
    slp <= 1'b0;
    $display("end of test wrap");
    acc(1, a_gt, 8'hD0);
    acc(1, a_gt, 8'hD8);
    step(0, 3);
    cnt(0);
    step(1, 4);
    cnt(4);
    step(0, 0);
    acc(0, a_gt, 8'h00);
    chk(rdat[3], 0);
    step(1, 4);
    cnt(0);
    acc(1, a_gt, 8'hC0);
    acc(1, a_gt, 8'hE0);
    step(0, 3);
    cnt(0);
    step(1, 0);
    step(0, 3);
    cnt(3);
    step(1, 0);
    step(0, 3);
    cnt(0);
    $display("end of test pulse");
    give_verdict;
  end
endmodule // tb_tgo_timer_gate
